//--- rtl/cw_quadrature_lo_divider.sv
// Purpose: per-channel I/Q LO generation by divide-by-M with programmable phase and array sync
// Assumes: AHB-Lite single-word transfers; multiple_lo_clock and divider_sync are asynchronous pins
// Notes: writes take no wait state, reads one; response is always OKAY
`timescale 1ns/1ns
`include "lo_divider_consts.svh"
module cw_quadrature_lo_divider (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pins
  input wire logic multiple_lo_clock,
  input wire logic divider_sync,
  // LO outputs to the mixers
  output logic [`LOD_CHANNELS-1:0] lo_in_phase,
  output logic [`LOD_CHANNELS-1:0] lo_quadrature
);

  lo_divider_pkg::ahb_req_type req_q;
  lo_divider_pkg::cw_cfg_type cfg_q;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;
  logic [`LOD_CHANNELS-1:0] chmask_q;
  logic [3:0] phase_q [`LOD_CHANNELS];
  logic [3:0] acc_q;
  logic [3:0] acc_d;
  logic [3:0] step;
  logic sync_seen_q;
  logic [`LOD_CHANNELS-1:0] lo_i_q;
  logic [`LOD_CHANNELS-1:0] lo_q_q;
  logic mlo_edge;
  logic sync_event;
  logic accept;
  logic wr_phase;
  logic wr_cfg;
  logic wr_mask;
  logic wr_status;
  logic [3:0] rd_phase;
  logic [31:0] rd_mux;

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign lo_in_phase = lo_i_q;
  assign lo_quadrature = lo_q_q;

  // ---------------- bus slave ----------------
  assign accept = hsel & htrans[`LOD_HTRANS_NONSEQ_BIT] & hready;
  assign wr_phase = wr_pend_q & (req_q.index == `LOD_IDX_PHASE);
  assign wr_cfg = wr_pend_q & (req_q.index == `LOD_IDX_CWCFG);
  assign wr_mask = wr_pend_q & (req_q.index == `LOD_IDX_CHMASK);
  assign wr_status = wr_pend_q & (req_q.index == `LOD_IDX_STATUS);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      wr_pend_q <= accept & hwrite;
      rd_pend_q <= accept & ~hwrite;
      // a read stretches its data phase by one cycle so hrdata comes from a flop
      hreadyout_q <= ~(accept & ~hwrite);
      hresp_q <= 1'b0;
      if (accept) begin
        req_q.index <= haddr[11:2];
        req_q.write <= hwrite;
      end
    end
  end

  // phase of the lowest selected channel is what a read shows
  always_comb begin
    rd_phase = 4'h0;
    for (int c = `LOD_CHANNELS - 1; c >= 0; c--) begin
      if (chmask_q[c]) begin
        rd_phase = phase_q[c];
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (req_q.index)
      `LOD_IDX_PHASE: rd_mux[`LOD_PHASE_LSB +: `LOD_PHASE_W] = rd_phase;
      `LOD_IDX_CWCFG: rd_mux[2:0] = {cfg_q.div_sel, cfg_q.sample_on_fall};
      `LOD_IDX_CHMASK: rd_mux[`LOD_CHANNELS-1:0] = chmask_q;
      `LOD_IDX_STATUS: begin
        rd_mux[`LOD_STAT_SYNC_BIT] = sync_seen_q;
        rd_mux[`LOD_STAT_ACC_LSB +: 4] = acc_q;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_pend_q) begin
      hrdata_q <= rd_mux;
    end
  end

  // ---------------- configuration ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= '0;
    end else if (wr_cfg) begin
      cfg_q.sample_on_fall <= hwdata[`LOD_CFG_EDGE_BIT];
      if (hwdata[`LOD_CFG_DIV_LSB +: `LOD_CFG_DIV_W] != `LOD_DIV_CODE_RSVD) begin
        cfg_q.div_sel <= hwdata[`LOD_CFG_DIV_LSB +: `LOD_CFG_DIV_W];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chmask_q <= `LOD_CHMASK_RESET;
    end else if (wr_mask) begin
      chmask_q <= hwdata[`LOD_CHANNELS-1:0];
    end
  end

  // sticky, write one to clear; a sync in the same cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_seen_q <= 1'b0;
    end else if (sync_event) begin
      sync_seen_q <= 1'b1;
    end else if (wr_status & hwdata[`LOD_STAT_SYNC_BIT]) begin
      sync_seen_q <= 1'b0;
    end
  end

  // ---------------- divider ----------------
  mlo_edge_sync u_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .multiple_lo_clock(multiple_lo_clock),
    .divider_sync(divider_sync),
    .sample_on_fall(cfg_q.sample_on_fall),
    .mlo_edge(mlo_edge),
    .sync_event(sync_event)
  );

  // a 16-step phase wheel advanced by 16/M per selected LO clock edge
  always_comb begin
    case (cfg_q.div_sel)
      `LOD_DIV_CODE_4: step = `LOD_STEP_4;
      `LOD_DIV_CODE_8: step = `LOD_STEP_8;
      default: step = `LOD_STEP_16;
    endcase
  end

  assign acc_d = sync_event ? 4'h0 : 4'(acc_q + step);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= 4'h0;
    end else if (mlo_edge) begin
      acc_q <= acc_d;
    end
  end

  // odd codes in divide by 4 just land between wheel positions; software avoids them
  for (genvar ch = 0; ch < `LOD_CHANNELS; ch++) begin : g_chan
    logic [3:0] pos;
    logic [3:0] qpos;
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        phase_q[ch] <= 4'h0;
      end else if (wr_phase & chmask_q[ch]) begin
        phase_q[ch] <= hwdata[`LOD_PHASE_LSB +: `LOD_PHASE_W];
      end
    end
    assign pos = 4'(acc_d + phase_q[ch]);
    // quadrature trails in-phase by a quarter turn of the wheel
    assign qpos = 4'(pos - `LOD_QUARTER);
    // the output flops move only on the LO edge, so divider glitches never reach the mixers
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        lo_i_q[ch] <= 1'b0;
        lo_q_q[ch] <= 1'b0;
      end else if (mlo_edge) begin
        lo_i_q[ch] <= ~pos[3];
        lo_q_q[ch] <= ~qpos[3];
      end
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [3:0] chk_pos;
  assign chk_pos = 4'(acc_q + phase_q[0]);

  a_wheel_step: assert property (mlo_edge && !sync_event |=> acc_q == 4'($past(acc_q) + $past(step)))
    else $error("divider wheel did not advance by 16/M");
  a_sync_known_state: assert property (sync_event |=> acc_q == 4'h0 ##1 !mlo_edge [*1] ##0 acc_q == 4'h0)
    else $error("sync did not force the divider to zero");
  a_ratio_select: assert property ((cfg_q.div_sel == `LOD_DIV_CODE_4 && step == `LOD_STEP_4)
    || (cfg_q.div_sel == `LOD_DIV_CODE_8 && step == `LOD_STEP_8)
    || (cfg_q.div_sel == `LOD_DIV_CODE_16 && step == `LOD_STEP_16))
    else $error("divide select does not match step");
  a_reserved_code_keeps: assert property (wr_cfg && hwdata[2:1] == `LOD_DIV_CODE_RSVD
    |=> $stable(cfg_q.div_sel))
    else $error("reserved divide code changed the ratio");
  a_lo_retimed: assert property (!mlo_edge |=> $stable(lo_i_q) && $stable(lo_q_q))
    else $error("LO output moved without an LO edge");
  a_sync_on_edge: assert property (sync_event |-> mlo_edge)
    else $error("sync acted away from the selected LO edge");
  a_phase_write: assert property (wr_phase && chmask_q[0] |=> phase_q[0] == $past(hwdata[3:0]))
    else $error("phase code not stored");
  a_lo_phase_value: assert property (mlo_edge && !wr_phase |=> lo_i_q[0] == ~chk_pos[3])
    else $error("in-phase LO does not follow wheel plus offset");

  c_sync_seen: cover property (sync_event);
  c_div4_edge: cover property (cfg_q.div_sel == `LOD_DIV_CODE_4 && mlo_edge);
  c_fall_sample: cover property (cfg_q.sample_on_fall && sync_event);
  c_reserved_write: cover property (wr_cfg && hwdata[2:1] == `LOD_DIV_CODE_RSVD);

endmodule : cw_quadrature_lo_divider

//--- pkg/lo_divider_consts.svh
// Purpose: register indices, field positions, reset values and counts of the LO divider
// Assumes: byte address of a register is four times its index
// Notes: definitions only
`ifndef LO_DIVIDER_CONSTS_SVH
`define LO_DIVIDER_CONSTS_SVH

`define LOD_CHANNELS 8
`define LOD_IDX_W 10
`define LOD_IDX_PHASE 10'h02D
`define LOD_IDX_CWCFG 10'h02E
`define LOD_IDX_CHMASK 10'h030
`define LOD_IDX_STATUS 10'h031
`define LOD_PHASE_LSB 0
`define LOD_PHASE_W 4
`define LOD_CFG_EDGE_BIT 0
`define LOD_CFG_DIV_LSB 1
`define LOD_CFG_DIV_W 2
`define LOD_STAT_SYNC_BIT 2
`define LOD_STAT_ACC_LSB 4
`define LOD_DIV_CODE_4 2'h0
`define LOD_DIV_CODE_8 2'h1
`define LOD_DIV_CODE_16 2'h2
`define LOD_DIV_CODE_RSVD 2'h3
`define LOD_STEP_4 4'h4
`define LOD_STEP_8 4'h2
`define LOD_STEP_16 4'h1
`define LOD_QUARTER 4'h4
`define LOD_CHMASK_RESET 8'hFF
`define LOD_HTRANS_NONSEQ_BIT 1

`endif

//--- pkg/lo_divider_pkg.sv
// Purpose: shared types of the quadrature LO divider
// Assumes: constants come from lo_divider_consts.svh
// Notes: nothing here is imported; users write lo_divider_pkg::name
package lo_divider_pkg;

  // captured AHB address phase
  typedef struct packed {
    logic [9:0] index;
    logic write;
  } ahb_req_type;

  // CW configuration register contents
  typedef struct packed {
    logic [1:0] div_sel;
    logic sample_on_fall;
  } cw_cfg_type;

endpackage : lo_divider_pkg

//--- rtl/mlo_edge_sync.sv
// Purpose: brings the multiple-LO clock and divider sync pins into hclk and finds the selected edges
// Assumes: hclk runs well above twice the multiple-LO rate
// Notes: outputs are one-cycle pulses on hclk
`timescale 1ns/1ns
module mlo_edge_sync (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // pins
  input wire logic multiple_lo_clock,
  input wire logic divider_sync,
  // control
  input wire logic sample_on_fall,
  // events
  output logic mlo_edge,
  output logic sync_event
);

  logic mlo_s1_q;
  logic mlo_s2_q;
  logic mlo_prev_q;
  logic sync_s1_q;
  logic sync_s2_q;
  logic sync_smp_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mlo_s1_q <= 1'b0;
      mlo_s2_q <= 1'b0;
      mlo_prev_q <= 1'b0;
      sync_s1_q <= 1'b0;
      sync_s2_q <= 1'b0;
    end else begin
      mlo_s1_q <= multiple_lo_clock;
      mlo_s2_q <= mlo_s1_q;
      mlo_prev_q <= mlo_s2_q;
      sync_s1_q <= divider_sync;
      sync_s2_q <= sync_s1_q;
    end
  end

  // the selected edge of the multiple-LO clock, rising or falling
  assign mlo_edge = sample_on_fall ? (mlo_prev_q & ~mlo_s2_q) : (~mlo_prev_q & mlo_s2_q);

  // sync is only looked at on the selected edge, so its own launch edge never races the sample
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_smp_q <= 1'b0;
    end else if (mlo_edge) begin
      sync_smp_q <= sync_s2_q;
    end
  end

  // edge triggered: a held-high sync acts once, a continuous one acts once per period of the sync signal
  assign sync_event = mlo_edge & sync_s2_q & ~sync_smp_q;

endmodule : mlo_edge_sync

//--- verification/lo_source_model.sv
// Purpose: multiple-LO clock and divider sync source
// Assumes: half period well above three hclk periods
// Notes: the clock stands low while run is low
`timescale 1ns/1ns
module lo_source_model #(parameter int HALF_NS = 60) (
  // control from the bench
  input wire logic run,
  input wire logic sync_req,
  input wire logic cont,
  input wire logic fall_sel,
  input wire logic [3:0] lo_half,
  // pins
  output logic multiple_lo_clock,
  output logic divider_sync
);
  logic done;
  logic [3:0] cnt;
  initial begin
    multiple_lo_clock = 1'b0;
    divider_sync = 1'b0;
    done = 1'b0;
    cnt = 4'h0;
    // odd offset keeps pin edges away from hclk edges
    #3;
    forever begin
      if (run) begin
        #HALF_NS multiple_lo_clock = 1'b1;
        #HALF_NS multiple_lo_clock = 1'b0;
      end else begin
        #10;
      end
    end
  end
  always @(multiple_lo_clock) begin
    if (multiple_lo_clock == fall_sel) begin
      if (cont) begin
        cnt = cnt + 4'h1;
        if (cnt >= lo_half) begin
          cnt = 4'h0;
          divider_sync = ~divider_sync;
        end
      end else begin
        divider_sync = sync_req & ~done;
        done = sync_req;
      end
    end
  end
endmodule : lo_source_model

//--- verification/cw_quadrature_lo_divider_tb.sv
// Purpose: self-checking bench of the LO divider
// Assumes: AHB master waits on hready; no fixed latency
// Notes: the LO clock is stopped while registers change
`timescale 1ns/1ns
`include "lo_divider_consts.svh"
module cw_quadrature_lo_divider_tb;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, div;
  logic [7:0] lo_i, lo_q, exp_i, exp_q;
  logic mlo, dsync, run, sreq, cont, fall, prev, synced;
  logic [3:0] half, wheel, step;
  logic [3:0] ph [8];
  int seed, miscompares, cmp_count;
  assign hready = hreadyout;
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  cw_quadrature_lo_divider i_cw_quadrature_lo_divider (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .multiple_lo_clock(mlo), .divider_sync(dsync),
    .lo_in_phase(lo_i), .lo_quadrature(lo_q));
  lo_source_model i_lo_source_model (.run(run), .sync_req(sreq), .cont(cont), .fall_sel(fall),
    .lo_half(half), .multiple_lo_clock(mlo), .divider_sync(dsync));
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      end_sim();
    end
  endtask : wait_rdy
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {20'h0, idx, 2'h0};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  // a pin edge is seen at most one hclk late
  task automatic wait_sel;
    int n;
    logic last;
    n = 0;
    do begin
      last = mlo;
      @(posedge hclk);
      n++;
    end while (!(mlo !== last && mlo === ~fall) && n < 40);
    if (!(mlo !== last && mlo === ~fall)) begin
      miscompares++;
      end_sim();
    end
  endtask : wait_sel
  function automatic logic [1:0] lo_exp(input logic [3:0] w, input logic [3:0] p);
    logic [3:0] s;
    logic [3:0] q;
    s = w + p;
    q = s - `LOD_QUARTER;
    return {~s[3], ~q[3]};
  endfunction : lo_exp
  initial begin
    seed = 8981;
    miscompares = 0;
    cmp_count = 0;
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {run, sreq, cont, fall, prev, synced, wheel} = '0;
    half = 4'h2;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, `LOD_IDX_PHASE, 32'h0); check("phase_rst", rd, 32'h0);
    bus(1'b0, `LOD_IDX_CWCFG, 32'h0); check("cfg_rst", rd, 32'h0);
    bus(1'b0, `LOD_IDX_CHMASK, 32'h0); check("mask_rst", rd, 32'hFF);
    bus(1'b0, `LOD_IDX_STATUS, 32'h0); check("stat_rst", rd, 32'h0);
    bus(1'b1, 10'h001, 32'hFFFFFFFF);
    bus(1'b0, 10'h001, 32'h0); check("unmapped", rd, 32'h0);
    check("hresp", {31'h0, hresp}, 32'h0);
    for (int i = 0; i < 6; i++) begin
      div = 2'(i % 3);
      fall = (i >= 3);
      step = (div == 2'h0) ? `LOD_STEP_4 : (div == 2'h1) ? `LOD_STEP_8 : `LOD_STEP_16;
      half = 4'h8 / step;
      bus(1'b1, `LOD_IDX_CWCFG, {29'h0, div, fall});
      // reserved divide code must leave the ratio alone
      bus(1'b1, `LOD_IDX_CWCFG, {29'h0, `LOD_DIV_CODE_RSVD, fall});
      bus(1'b0, `LOD_IDX_CWCFG, 32'h0); check("cfg", rd, {29'h0, div, fall});
      for (int c = 0; c < 8; c++) begin
        ph[c] = 4'($random(seed));
        if (div == `LOD_DIV_CODE_4) ph[c][0] = 1'b0;
        bus(1'b1, `LOD_IDX_CHMASK, 32'h1 << c);
        bus(1'b1, `LOD_IDX_PHASE, {28'h0, ph[c]});
        bus(1'b0, `LOD_IDX_PHASE, 32'h0); check("phase", rd, {28'h0, ph[c]});
      end
      cont = (i == 5);
      synced = 1'b0;
      run = 1'b1;
      sreq = 1'b1;
      for (int k = 0; k < 40; k++) begin
        wait_sel();
        if (dsync === 1'b1 && !prev) begin
          wheel = 4'h0;
          synced = 1'b1;
        end else begin
          wheel = wheel + step;
        end
        prev = dsync;
        repeat (5) @(posedge hclk);
        for (int c = 0; c < 8; c++) {exp_i[c], exp_q[c]} = lo_exp(wheel, ph[c]);
        if (synced) check("lo_i", {24'h0, lo_i}, {24'h0, exp_i});
        if (synced) check("lo_q", {24'h0, lo_q}, {24'h0, exp_q});
      end
      run = 1'b0;
      sreq = 1'b0;
      repeat (30) @(posedge hclk);
      bus(1'b0, `LOD_IDX_STATUS, 32'h0); check("sync_seen", {31'h0, rd[2]}, 32'h1);
      bus(1'b1, `LOD_IDX_STATUS, 32'h4);
      bus(1'b0, `LOD_IDX_STATUS, 32'h0); check("sync_clr", {31'h0, rd[2]}, 32'h0);
    end
    end_sim();
  end
endmodule : cw_quadrature_lo_divider_tb
